/* hw/pfcs_top.sv */
// Port zero flow control register: storage, status and resolution
// Operation
// - Bit 6 set enables half-duplex backpressure generation on the port.
// - Read-only bit 5 shows duplex in effect, one meaning half.
// - Read-only bit 4 shows receive pause in effect, manual or negotiated.
// - Read-only bit 3 shows transmit pause in effect.
// - Bit 2 enables receive pause when manual or negotiation disabled.
// - Bit 1 enables transmit pause when manual or negotiation disabled.
// - Manual clear and negotiation on: negotiated result used, bits ignored.
// - Manual clear and negotiation off: enable bits applied directly.
// - Manual set: enable bits decide flow control in full duplex.
// - In MAC mode the manual select bit is held at one.
// - Manual select writable except in MAC mode, where writes ignored.
// - Writable defaults come from straps; loader rewrites update fields.
// - MAC mode manual default one, not overwritten by loader.
// - Writes never change the emulated advertisement pause values.
// - Status bits clear in reset, then follow the resolved link inputs and enable bits.
`timescale 1ns/1ps
module pfcs_top (
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire logic [11:0]          reg_addr,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [31:0]          reg_wdata,
    output logic      [31:0]          reg_rdata,
    input  wire pfcs_pkg::pfcs_strap_s strap_in,
    input  wire logic                 strap_reload,
    input  wire logic                 mac_mode,
    input  wire logic                 an_enable,
    input  wire logic                 an_rx_pause,
    input  wire logic                 an_tx_pause,
    input  wire logic                 half_duplex,
    output logic                      backpressure_enable,
    output logic                      port_rx_pause_active,
    output logic                      port_tx_pause_active,
    output logic                      port_half_duplex
);
    ////////////////////////////////////////////////////////////////////////
    logic                     bp_en_r;
    logic                     rx_en_r;
    logic                     tx_en_r;
    logic                     manual_r;
    logic                     init_r;
    logic                     hit_wr;
    logic                     load;
    pfcs_pkg::pfcs_resolved_s res;
    pfcs_pkg::pfcs_resolved_s status_r;

    assign hit_wr = reg_wr && (reg_addr == pfcs_pkg::PFCS_OFF_FLOW_CTRL);
    // Straps caught by a clocked load after release, never in reset
    assign load   = ~init_r | strap_reload;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            init_r <= 1'b0;
        end else begin
            init_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // backpressure field
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bp_en_r <= 1'b0;
        end else if (load) begin
            bp_en_r <= strap_in.backpressure_default_strap;
        end else if (hit_wr) begin
            bp_en_r <= reg_wdata[pfcs_pkg::PFCS_BIT_BP_EN];
        end
    end

    // pause enable fields, fed to the resolver
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end else if (load) begin
            rx_en_r <= strap_in.pause_default_strap;
            tx_en_r <= strap_in.pause_default_strap;
        end else if (hit_wr) begin
            rx_en_r <= reg_wdata[pfcs_pkg::PFCS_BIT_RX_EN];
            tx_en_r <= reg_wdata[pfcs_pkg::PFCS_BIT_TX_EN];
        end
    end

    // manual select, forced in MAC mode
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            manual_r <= 1'b1;
        end else if (mac_mode) begin
            manual_r <= 1'b1;
        end else if (load) begin
            manual_r <= strap_in.manual_select_default_strap;
        end else if (hit_wr) begin
            manual_r <= reg_wdata[pfcs_pkg::PFCS_BIT_MANUAL];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    pfcs_resolve pfcs_resolve_i (
        .manual_sel  (manual_r),
        .rx_en       (rx_en_r),
        .tx_en       (tx_en_r),
        .an_enable   (an_enable),
        .an_rx_pause (an_rx_pause),
        .an_tx_pause (an_tx_pause),
        .half_duplex (half_duplex),
        .resolved    (res)
    );

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            status_r <= '0;
        end else begin
            status_r <= res;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            backpressure_enable  <= 1'b0;
            port_rx_pause_active <= 1'b0;
            port_tx_pause_active <= 1'b0;
            port_half_duplex     <= 1'b0;
        end else begin
            backpressure_enable  <= bp_en_r;
            port_rx_pause_active <= res.current_rx_pause_enable;
            port_tx_pause_active <= res.current_tx_pause_enable;
            port_half_duplex     <= res.current_duplex;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read path, reserved bits zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= pfcs_pkg::PFCS_RSV_VALUE;
        end else if (reg_rd &&
                     reg_addr == pfcs_pkg::PFCS_OFF_FLOW_CTRL) begin
            reg_rdata <= pfcs_pkg::PFCS_RSV_VALUE;
            reg_rdata[pfcs_pkg::PFCS_BIT_BP_EN]   <= bp_en_r;
            reg_rdata[pfcs_pkg::PFCS_BIT_CUR_DUP] <=
                status_r.current_duplex;
            reg_rdata[pfcs_pkg::PFCS_BIT_CUR_RX]  <=
                status_r.current_rx_pause_enable;
            reg_rdata[pfcs_pkg::PFCS_BIT_CUR_TX]  <=
                status_r.current_tx_pause_enable;
            reg_rdata[pfcs_pkg::PFCS_BIT_RX_EN]   <= rx_en_r;
            reg_rdata[pfcs_pkg::PFCS_BIT_TX_EN]   <= tx_en_r;
            reg_rdata[pfcs_pkg::PFCS_BIT_MANUAL]  <= manual_r;
        end else if (reg_rd) begin
            // Unmapped reads return zero
            reg_rdata <= pfcs_pkg::PFCS_RSV_VALUE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Write taken; a strap load in the same cycle wins
    sequence wr_taken_seq;
        hit_wr && !load;
    endsequence

    // Loader rewrite outside MAC mode
    sequence reload_seq;
        strap_reload && !mac_mode;
    endsequence

    // Host read of the mapped word
    sequence mapped_rd_seq;
        reg_rd && (reg_addr == pfcs_pkg::PFCS_OFF_FLOW_CTRL);
    endsequence

    // Full duplex with manual bits in charge
    sequence manual_full_seq;
        (manual_r || !an_enable) && !half_duplex;
    endsequence

    // Full duplex with negotiation in charge
    sequence an_full_seq;
        !manual_r && an_enable && !half_duplex;
    endsequence

    AST_MAC_MANUAL: assert property (
        @(posedge mclk) disable iff (sys_rst)
        mac_mode |=> manual_r)
        else $error("manual select low in MAC mode");

    AST_MAC_WR_IGNORED: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (hit_wr && mac_mode && init_r) |=> manual_r)
        else $error("MAC mode manual select written");

    AST_WR_MANUAL: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (hit_wr && !load && !mac_mode) |=>
        manual_r == $past(reg_wdata[pfcs_pkg::PFCS_BIT_MANUAL]))
        else $error("manual select write lost");

    AST_WR_PAUSE: assert property (
        @(posedge mclk) disable iff (sys_rst)
        wr_taken_seq |=>
        (rx_en_r == $past(reg_wdata[pfcs_pkg::PFCS_BIT_RX_EN])) &&
        (tx_en_r == $past(reg_wdata[pfcs_pkg::PFCS_BIT_TX_EN])))
        else $error("pause enable write lost");

    AST_BP_FIELD: assert property (
        @(posedge mclk) disable iff (sys_rst)
        wr_taken_seq |=>
        bp_en_r == $past(reg_wdata[pfcs_pkg::PFCS_BIT_BP_EN]))
        else $error("backpressure field write lost");

    AST_BP_WRITE: assert property (
        @(posedge mclk) disable iff (sys_rst)
        wr_taken_seq |=> ##1 backpressure_enable ==
        $past(reg_wdata[pfcs_pkg::PFCS_BIT_BP_EN], 2))
        else $error("backpressure output wrong after write");

    AST_HALF_NO_PAUSE: assert property (
        @(posedge mclk) disable iff (sys_rst)
        half_duplex |=> !port_rx_pause_active && !port_tx_pause_active)
        else $error("pause active in half duplex");

    AST_AN_PATH: assert property (
        @(posedge mclk) disable iff (sys_rst)
        an_full_seq |=>
        (port_rx_pause_active == $past(an_rx_pause)) &&
        (port_tx_pause_active == $past(an_tx_pause)))
        else $error("negotiated pause not applied");

    AST_MANUAL_PATH: assert property (
        @(posedge mclk) disable iff (sys_rst)
        manual_full_seq |=>
        (port_rx_pause_active == $past(rx_en_r)) &&
        (port_tx_pause_active == $past(tx_en_r)))
        else $error("manual pause not applied");

    AST_RELOAD: assert property (
        @(posedge mclk) disable iff (sys_rst)
        reload_seq |=>
        (rx_en_r == $past(strap_in.pause_default_strap)) &&
        (manual_r == $past(strap_in.manual_select_default_strap)))
        else $error("strap reload not applied");

    AST_RELOAD_BP: assert property (
        @(posedge mclk) disable iff (sys_rst)
        strap_reload |=>
        (bp_en_r == $past(strap_in.backpressure_default_strap)) &&
        (tx_en_r == $past(strap_in.pause_default_strap)))
        else $error("strap reload missed a field");

    AST_MAC_RELOAD: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (strap_reload && mac_mode) |=> manual_r)
        else $error("loader cleared manual select in MAC mode");

    AST_DUP_STATUS: assert property (
        @(posedge mclk) disable iff (sys_rst)
        half_duplex ##1 half_duplex |=> status_r.current_duplex)
        else $error("duplex status stale");

    AST_FULL_STATUS: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !half_duplex |=> !status_r.current_duplex)
        else $error("full duplex status wrong");

    AST_RD_HALF: assert property (
        @(posedge mclk) disable iff (sys_rst)
        half_duplex ##1 mapped_rd_seq |=>
        reg_rdata[pfcs_pkg::PFCS_BIT_CUR_DUP] &&
        !reg_rdata[pfcs_pkg::PFCS_BIT_CUR_RX] &&
        !reg_rdata[pfcs_pkg::PFCS_BIT_CUR_TX])
        else $error("half duplex status read wrong");

    AST_RD_FIELDS: assert property (
        @(posedge mclk) disable iff (sys_rst)
        mapped_rd_seq |=>
        (reg_rdata[pfcs_pkg::PFCS_BIT_BP_EN] == $past(bp_en_r)) &&
        (reg_rdata[pfcs_pkg::PFCS_BIT_RX_EN] == $past(rx_en_r)) &&
        (reg_rdata[pfcs_pkg::PFCS_BIT_TX_EN] == $past(tx_en_r)) &&
        (reg_rdata[pfcs_pkg::PFCS_BIT_MANUAL] == $past(manual_r)))
        else $error("writable field read back wrong");

    AST_RD_UNMAPPED: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (reg_rd && (reg_addr != pfcs_pkg::PFCS_OFF_FLOW_CTRL)) |=>
        (reg_rdata == pfcs_pkg::PFCS_RSV_VALUE))
        else $error("unmapped read not zero");

    AST_RDATA_HOLD: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    AST_RSV_ZERO: assert property (
        @(posedge mclk) disable iff (sys_rst)
        reg_rdata[31:7] == 25'h000_0000)
        else $error("reserved bits nonzero");
endmodule

/* hw/pfcs_pkg.sv */
// Package: offsets, field positions and carriers for port flow control
package pfcs_pkg;
    localparam logic [11:0] PFCS_OFF_FLOW_CTRL = 12'h01a8;
    localparam int          PFCS_BIT_BP_EN     = 6;
    localparam int          PFCS_BIT_CUR_DUP   = 5;
    localparam int          PFCS_BIT_CUR_RX    = 4;
    localparam int          PFCS_BIT_CUR_TX    = 3;
    localparam int          PFCS_BIT_RX_EN     = 2;
    localparam int          PFCS_BIT_TX_EN     = 1;
    localparam int          PFCS_BIT_MANUAL    = 0;
    localparam logic [31:0] PFCS_RSV_VALUE     = 32'h0000_0000;
    localparam logic        PFCS_DUP_FULL      = 1'b0;
    localparam logic        PFCS_DUP_HALF      = 1'b1;

    // Strap values as latched on the first clock after reset release or rewritten by the loader
    typedef struct packed {
        logic backpressure_default_strap;
        logic pause_default_strap;
        logic manual_select_default_strap;
    } pfcs_strap_s;

    // Resolved port flow control settings
    typedef struct packed {
        logic current_duplex;
        logic current_rx_pause_enable;
        logic current_tx_pause_enable;
    } pfcs_resolved_s;
endpackage

/* hw/pfcs_resolve.sv */
// Flow control resolution from manual bits and negotiation result
`timescale 1ns/1ps
module pfcs_resolve (
    input  wire logic                    manual_sel,
    input  wire logic                    rx_en,
    input  wire logic                    tx_en,
    input  wire logic                    an_enable,
    input  wire logic                    an_rx_pause,
    input  wire logic                    an_tx_pause,
    input  wire logic                    half_duplex,
    output pfcs_pkg::pfcs_resolved_s     resolved
);
    logic use_manual;

    assign use_manual = manual_sel | ~an_enable;

    always_comb begin
        resolved.current_duplex = half_duplex;
        if (half_duplex) begin
            resolved.current_rx_pause_enable = 1'b0;
            resolved.current_tx_pause_enable = 1'b0;
        end else if (use_manual) begin
            resolved.current_rx_pause_enable = rx_en;
            resolved.current_tx_pause_enable = tx_en;
        end else begin
            resolved.current_rx_pause_enable = an_rx_pause;
            resolved.current_tx_pause_enable = an_tx_pause;
        end
    end
endmodule

/* bench/pfcs_top_tb_top.sv */
// Self-checking bench for the port flow control register
`timescale 1ns/1ps
module pfcs_top_tb_top;
    logic                  mclk;
    logic                  sys_rst;
    logic [11:0]           reg_addr;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [31:0]           reg_wdata;
    logic [31:0]           reg_rdata;
    pfcs_pkg::pfcs_strap_s strap_in;
    logic                  strap_reload;
    logic                  mac_mode;
    logic                  an_enable;
    logic                  an_rx_pause;
    logic                  an_tx_pause;
    logic                  half_duplex;
    logic                  backpressure_enable;
    logic                  port_rx_pause_active;
    logic                  port_tx_pause_active;
    logic                  port_half_duplex;
    logic                  rd_d;
    logic [31:0]           seed;
    logic [31:0]           expq[$];
    logic                  bp, rx, tx, man;
    int                    n_errors;
    int                    checks_done;
    pfcs_top pfcs_top_i (
        .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .strap_in(strap_in),
        .strap_reload(strap_reload), .mac_mode(mac_mode),
        .an_enable(an_enable), .an_rx_pause(an_rx_pause),
        .an_tx_pause(an_tx_pause), .half_duplex(half_duplex),
        .backpressure_enable(backpressure_enable),
        .port_rx_pause_active(port_rx_pause_active),
        .port_tx_pause_active(port_tx_pause_active),
        .port_half_duplex(port_half_duplex)
    );
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Reference view of the word; pause status dropped in half duplex
    function automatic logic [31:0] exp_word();
        logic m, crx, ctx;
        m = mac_mode | man;
        crx = half_duplex ? 1'b0 : ((m | !an_enable) ? rx : an_rx_pause);
        ctx = half_duplex ? 1'b0 : ((m | !an_enable) ? tx : an_tx_pause);
        return {25'h000_0000, bp, half_duplex, crx, ctx, rx, tx, m};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Read data lands one edge after the strobe is taken
    always @(posedge mclk) rd_d <= reg_rd;
    always @(negedge mclk) begin
        if (rd_d === 1'b1) begin
            chk(reg_rdata, expq.pop_front());
        end
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        expq.push_back(e);
        @(posedge mclk);
        #1;
        reg_rd = 1'b0;
    endtask
    task automatic load_model(input pfcs_pkg::pfcs_strap_s s);
        bp = s.backpressure_default_strap;
        rx = s.pause_default_strap;
        tx = s.pause_default_strap;
        man = mac_mode | s.manual_select_default_strap;
    endtask
    // Status lags link inputs by one cycle, so wait past that
    task automatic settle();
        repeat (4) @(posedge mclk);
        #1;
    endtask
    task automatic outs();
        logic [31:0] e;
        e = exp_word();
        chk({28'h000_0000, backpressure_enable, port_half_duplex,
             port_rx_pause_active, port_tx_pause_active},
            {28'h000_0000, e[6], e[5], e[4], e[3]});
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic phase(input logic mac);
        logic [31:0] r;
        r = xs();
        sys_rst = 1'b1;
        mac_mode = mac;
        strap_in = r[2:0];
        repeat (2) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        load_model(r[2:0]);
        settle();
        rd(pfcs_pkg::PFCS_OFF_FLOW_CTRL, exp_word());
        for (int i = 0; i < 40; i++) begin
            r = xs();
            an_enable = r[8];
            an_rx_pause = r[9];
            an_tx_pause = r[10];
            half_duplex = r[11];
            if (r[12] && r[13]) begin
                @(posedge mclk);
                #1;
                strap_in = r[5:3];
                strap_reload = 1'b1;
                @(posedge mclk);
                #1;
                strap_reload = 1'b0;
                load_model(r[5:3]);
            end else if (r[12]) begin
                wr(12'h01ac, r);
                rd(12'h01ac, 32'h0000_0000);
            end else begin
                // manual select ignored in MAC mode
                wr(pfcs_pkg::PFCS_OFF_FLOW_CTRL, r);
                bp = r[6];
                rx = r[2];
                tx = r[1];
                if (!mac) man = r[0];
            end
            settle();
            rd(pfcs_pkg::PFCS_OFF_FLOW_CTRL,
               exp_word());
            outs();
        end
        // Last read must be checked before the next reset clears it
        settle();
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, strap_reload} = 4'h8;
        {reg_addr, reg_wdata} = 44'h000_0000_0000;
        {strap_in, mac_mode, an_enable, an_rx_pause} = 6'h00;
        {an_tx_pause, half_duplex, man} = 3'h1;
        {bp, rx, tx} = 3'h0;
        seed = 32'h0000_1944;
        n_errors = 0;
        checks_done = 0;
        phase(1'b0);
        phase(1'b1);
        repeat (4) @(posedge mclk);
        results();
    end
    // Run needs about 14 us; 250 us, over seventeen times that, is a hang
    initial begin
        #250000;
        n_errors++;
        results();
    end
endmodule
